// [core/barrel_shifter.sv]
// combinational barrel shifter, left, right logical, right arithmetic
`timescale 1ns/1ps
module barrel_shifter (
	shift_if.unit sh
);
	// type picks sign fill, zero amount passes through
	always_comb begin
		if (sh.left) begin
			sh.result = sh.src << sh.amount;
		end else if (sh.arith) begin
			sh.result = $unsigned($signed(sh.src) >>> sh.amount);
		end else begin
			sh.result = sh.src >> sh.amount;
		end
	end
endmodule

// [core/branch_and_barrel_shift_exec.sv]
// execute logic for not-equal, unconditional, break and shift instructions
`timescale 1ns/1ps
module branch_and_barrel_shift_exec #(
	parameter bit BARREL_EN = 1'b1
) (
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	input  wire logic        instr_valid,
	input  wire logic [31:0] instr,
	output logic             instr_ready,
	output logic [4:0]       first_source_sel,
	output logic [4:0]       second_source_sel,
	input  wire logic [31:0] first_source_reg,
	input  wire logic [31:0] second_source_reg,
	input  wire logic        break_clear,
	output logic [31:0]      program_counter,
	output logic             dest_we,
	output logic [4:0]       dest_sel,
	output logic [31:0]      dest_data,
	output logic             branch_taken,
	output logic             delay_slot,
	output logic             break_in_progress_flag,
	output logic             illegal_op
);
	function automatic logic op_match(input logic [5:0] op,
		input logic [5:0] base);
		return (op & ~branch_exec_pkg::IMM_FORM_MASK) == base;
	endfunction

	function automatic logic [31:0] literal(input logic [15:0] lit,
		input logic pre_valid, input logic [15:0] pre);
		return pre_valid ? {pre, lit} : {{16{lit[15]}}, lit};
	endfunction

	branch_exec_pkg::exec_e state;
	branch_exec_pkg::exec_e next_state;
	logic [1:0]  wait_cnt;
	logic [1:0]  next_wait;
	logic [31:0] next_pc;
	logic [31:0] pend_target;
	logic [31:0] next_pend_target;
	logic        pend_valid;
	logic        next_pend_valid;
	logic [15:0] prefix;
	logic [15:0] next_prefix;
	logic        prefix_valid;
	logic        next_prefix_valid;
	logic        next_dest_we;
	logic [4:0]  next_dest_sel;
	logic [31:0] next_dest_data;
	logic        next_branch_taken;
	logic        next_delay_slot;
	logic        next_bip;
	logic        next_illegal;

	logic        take;
	logic [5:0]  opcode;
	logic        imm_form;
	logic        is_cond;
	logic        is_unc;
	logic        is_break;
	logic        is_shift;
	logic        is_prefix;
	logic        cond_dly;
	logic        unc_dly;
	logic        unc_abs;
	logic        unc_link;
	logic [31:0] lit_val;
	logic [31:0] operand;
	logic        jump;
	logic        jump_dly;
	logic [31:0] jump_target;
	logic [1:0]  lat;

	shift_if sh ();

	barrel_shifter u_shift (
		.sh (sh.unit)
	);

	assign take = instr_valid && (state == branch_exec_pkg::EXEC_READY);
	assign instr_ready = (state == branch_exec_pkg::EXEC_READY);
	assign opcode = instr[branch_exec_pkg::OPC_HI:branch_exec_pkg::OPC_LO];
	assign imm_form = |(opcode & branch_exec_pkg::IMM_FORM_MASK);
	assign first_source_sel =
		instr[branch_exec_pkg::RA_HI:branch_exec_pkg::RA_LO];
	assign second_source_sel =
		instr[branch_exec_pkg::RB_HI:branch_exec_pkg::RB_LO];

	assign is_cond = op_match(opcode, branch_exec_pkg::OP_BCOND) &&
		instr[branch_exec_pkg::COND_HI:branch_exec_pkg::COND_LO] ==
		branch_exec_pkg::COND_NE;
	assign cond_dly = instr[branch_exec_pkg::COND_DLY_BIT];
	assign is_unc = op_match(opcode, branch_exec_pkg::OP_BUNC);
	assign unc_dly = instr[branch_exec_pkg::UNC_DLY_BIT];
	assign unc_abs = instr[branch_exec_pkg::UNC_ABS_BIT];
	assign unc_link = instr[branch_exec_pkg::UNC_LINK_BIT];
	// break is the link-without-delay absolute encoding
	assign is_break = is_unc && unc_link && !unc_dly && unc_abs;
	assign is_shift = op_match(opcode, branch_exec_pkg::OP_SHIFT);
	assign is_prefix = opcode == branch_exec_pkg::OP_PREFIX;
	assign lit_val = literal(
		instr[branch_exec_pkg::LIT_HI:branch_exec_pkg::LIT_LO],
		prefix_valid, prefix);
	assign operand = imm_form ? lit_val : second_source_reg;

	// side, type and immediate amount bits
	// immediate amount never sees the prefix
	// register amount from low five bits
	assign sh.src = first_source_reg;
	assign sh.left = instr[branch_exec_pkg::SIDE_BIT];
	assign sh.arith = instr[branch_exec_pkg::TYPE_BIT];
	assign sh.amount = imm_form ?
		instr[branch_exec_pkg::SHAMT_HI:branch_exec_pkg::SHAMT_LO] :
		second_source_reg[4:0];

	always_comb begin
		next_state = state;
		next_wait = wait_cnt;
		next_pc = program_counter;
		next_pend_target = pend_target;
		next_pend_valid = pend_valid;
		next_prefix = prefix;
		next_prefix_valid = prefix_valid;
		next_dest_we = 1'b0;
		next_dest_sel = dest_sel;
		next_dest_data = dest_data;
		next_branch_taken = 1'b0;
		next_delay_slot = 1'b0;
		next_illegal = 1'b0;
		// set wins over a clear in the same cycle
		next_bip = break_in_progress_flag & ~break_clear;
		jump = 1'b0;
		jump_dly = 1'b0;
		jump_target = program_counter;
		lat = branch_exec_pkg::LAT_SINGLE;
		if (take) begin
			// sequential step, or the target held over a delay slot
			next_pc = pend_valid ? pend_target :
				program_counter + branch_exec_pkg::PC_STEP;
			next_pend_valid = 1'b0;
			next_prefix_valid = 1'b0;
			next_dest_sel = instr[branch_exec_pkg::RD_HI:branch_exec_pkg::RD_LO];
			if (is_cond) begin
				// taken when first source is nonzero
				if (first_source_reg != 32'h00000000) begin
					jump = 1'b1;
					jump_dly = cond_dly;
					jump_target = program_counter + operand;
				end else begin
					lat = branch_exec_pkg::LAT_NOT_TAKEN;
				end
			end else if (is_break) begin
				next_dest_we = 1'b1;
				next_dest_data = program_counter;
				next_pc = operand;
				next_bip = 1'b1;
				next_branch_taken = 1'b1;
				lat = branch_exec_pkg::LAT_BREAK;
			end else if (is_unc && unc_link && !unc_dly) begin
				// relative link without delay slot does not exist
				next_illegal = 1'b1;
			end else if (is_unc) begin
				jump = 1'b1;
				jump_dly = unc_dly;
				jump_target = unc_abs ? operand : program_counter + operand;
				next_dest_we = unc_link;
				next_dest_data = program_counter;
			end else if (is_prefix) begin
				next_prefix_valid = 1'b1;
				next_prefix = instr[branch_exec_pkg::LIT_HI:branch_exec_pkg::LIT_LO];
			end else if (is_shift && BARREL_EN) begin
				next_dest_we = 1'b1;
				next_dest_data = sh.result;
				lat = branch_exec_pkg::LAT_SHIFT;
			end else begin
				// not ours or shifter left out: step on and flag it
				next_illegal = 1'b1;
			end
			// delay slot holds target one instruction
			if (jump) begin
				next_branch_taken = 1'b1;
				if (jump_dly) begin
					next_pc = program_counter + branch_exec_pkg::PC_STEP;
					next_pend_target = jump_target;
					next_pend_valid = 1'b1;
					next_delay_slot = 1'b1;
					lat = branch_exec_pkg::LAT_TAKEN_DLY;
				end else begin
					next_pc = jump_target;
					lat = branch_exec_pkg::LAT_TAKEN;
				end
			end
			next_wait = lat - 2'h1;
			next_state = (lat > 2'h1) ? branch_exec_pkg::EXEC_STALL :
				branch_exec_pkg::EXEC_READY;
		end else if (state == branch_exec_pkg::EXEC_STALL) begin
			next_wait = wait_cnt - 2'h1;
			if (wait_cnt == 2'h1) begin
				next_state = branch_exec_pkg::EXEC_READY;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state <= branch_exec_pkg::EXEC_READY;
			wait_cnt <= 2'h0;
			program_counter <= branch_exec_pkg::PC_RESET;
			pend_target <= 32'h00000000;
			pend_valid <= 1'b0;
			prefix <= 16'h0000;
			prefix_valid <= 1'b0;
			dest_we <= 1'b0;
			dest_sel <= 5'h00;
			dest_data <= 32'h00000000;
			branch_taken <= 1'b0;
			delay_slot <= 1'b0;
			break_in_progress_flag <= 1'b0;
			illegal_op <= 1'b0;
		end else begin
			state <= next_state;
			wait_cnt <= next_wait;
			program_counter <= next_pc;
			pend_target <= next_pend_target;
			pend_valid <= next_pend_valid;
			prefix <= next_prefix;
			prefix_valid <= next_prefix_valid;
			dest_we <= next_dest_we;
			dest_sel <= next_dest_sel;
			dest_data <= next_dest_data;
			branch_taken <= next_branch_taken;
			delay_slot <= next_delay_slot;
			break_in_progress_flag <= next_bip;
			illegal_op <= next_illegal;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);

	chk_reg_branch_target:
	assert property (take && is_cond && !imm_form && !cond_dly &&
		first_source_reg != 32'h00000000 |=>
		program_counter == $past(program_counter) + $past(second_source_reg))
	else $error("register branch target wrong");

	chk_imm_branch_target:
	assert property (take && is_cond && imm_form && !cond_dly &&
		!prefix_valid && first_source_reg != 32'h00000000 |=>
		program_counter == $past(program_counter) +
		{{16{$past(instr[15])}}, $past(instr[15:0])})
	else $error("immediate branch target wrong");

	chk_untaken_step:
	assert property (take && is_cond && !pend_valid &&
		first_source_reg == 32'h00000000 |=>
		program_counter == $past(program_counter) + 32'h00000004 &&
		instr_ready && !branch_taken)
	else $error("untaken branch did not step four");

	chk_delay_then_target:
	assert property (take && jump && jump_dly |=> delay_slot && pend_valid &&
		pend_target == $past(jump_target) ##1 instr_ready)
	else $error("delay slot did not lead to target");
	chk_slot_loads_target:
	assert property (take && pend_valid && !jump && !is_break |=>
		program_counter == $past(pend_target))
	else $error("delay slot instruction not followed by target");
	chk_taken_three_cycles:
	assert property (take && jump && !jump_dly |=>
		!instr_ready [*2] ##1 instr_ready)
	else $error("taken branch without delay not three cycles");
	chk_taken_two_cycles:
	assert property (take && jump && jump_dly |=>
		!instr_ready ##1 instr_ready)
	else $error("delayed branch not two cycles");
	chk_link_stores_pc:
	assert property (take && is_unc && unc_link && unc_dly |=>
		dest_we && dest_data == $past(program_counter) &&
		dest_sel == $past(instr[25:21]))
	else $error("link did not store branch address");

	chk_no_link_no_delay:
	assert property (take && is_unc && unc_link && !unc_dly && !unc_abs |=>
		illegal_op && !dest_we && !branch_taken)
	else $error("link without delay was executed");

	chk_break_effects:
	assert property (take && is_break |=> break_in_progress_flag &&
		dest_data == $past(program_counter) &&
		program_counter == $past(operand) ##0 !instr_ready [*2] ##1
		instr_ready)
	else $error("break effects or latency wrong");

	chk_shift_two_cycles:
	assert property (BARREL_EN && take && is_shift |=> dest_we &&
		dest_data == $past(sh.result) ##0 !instr_ready ##1 instr_ready)
	else $error("shift result or latency wrong");
	chk_prefix_join:
	assert property (take && prefix_valid && imm_form && is_unc && unc_abs &&
		!unc_dly |=> program_counter == {$past(prefix), $past(instr[15:0])})
	else $error("prefix not joined into literal");
	chk_shift_ignores_prefix:
	assert property (take && is_shift && imm_form |->
		sh.amount == instr[4:0])
	else $error("shift amount took prefix");
endmodule

// [core/branch_exec_pkg.sv]
// constants for the branch and barrel shift execute block
package branch_exec_pkg;
	localparam int XLEN          = 32;
	// opcode field and register fields, msb-first bit 0 is bit 31 here
	localparam int OPC_HI        = 31;
	localparam int OPC_LO        = 26;
	localparam int RD_HI         = 25;
	localparam int RD_LO         = 21;
	localparam int RA_HI         = 20;
	localparam int RA_LO         = 16;
	localparam int RB_HI         = 15;
	localparam int RB_LO         = 11;
	localparam int LIT_HI        = 15;
	localparam int LIT_LO        = 0;
	localparam int COND_DLY_BIT  = 25;
	localparam int COND_HI       = 24;
	localparam int COND_LO       = 21;
	localparam int UNC_DLY_BIT   = 20;
	localparam int UNC_ABS_BIT   = 19;
	localparam int UNC_LINK_BIT  = 18;
	localparam int SIDE_BIT      = 10;
	localparam int TYPE_BIT      = 9;
	localparam int SHAMT_HI      = 4;
	localparam int SHAMT_LO      = 0;
	// branch and shift opcodes with the immediate-form bit cleared, prefix opcode with it set
	localparam logic [5:0] IMM_FORM_MASK = 6'h08;
	localparam logic [5:0] OP_BCOND      = 6'h27;
	localparam logic [5:0] OP_BUNC       = 6'h26;
	localparam logic [5:0] OP_SHIFT      = 6'h11;
	localparam logic [5:0] OP_PREFIX     = 6'h2C;
	localparam logic [3:0] COND_NE       = 4'h1;
	// latencies in cycles
	localparam logic [1:0] LAT_NOT_TAKEN = 2'h1;
	localparam logic [1:0] LAT_TAKEN_DLY = 2'h2;
	localparam logic [1:0] LAT_TAKEN     = 2'h3;
	localparam logic [1:0] LAT_BREAK     = 2'h3;
	localparam logic [1:0] LAT_SHIFT     = 2'h2;
	localparam logic [1:0] LAT_SINGLE    = 2'h1;
	localparam logic [31:0] PC_STEP      = 32'h00000004;
	localparam logic [31:0] PC_RESET     = 32'h00000000;
	typedef enum logic {
		EXEC_READY = 1'b0,
		EXEC_STALL = 1'b1
	} exec_e;
endpackage

// [core/shift_if.sv]
// request and result of the barrel shifter
`timescale 1ns/1ps
interface shift_if;
	logic [31:0] src;
	logic [4:0]  amount;
	logic        left;
	logic        arith;
	logic [31:0] result;
	modport core (output src, output amount, output left, output arith,
		input result);
	modport unit (input src, input amount, input left, input arith,
		output result);
endinterface

// [sim/branch_and_barrel_shift_exec_tb.sv]
// self-checking testbench for the branch and shift execute block
`timescale 1ns/1ps
module branch_and_barrel_shift_exec_tb;
	typedef struct {
		logic [31:0] pc;
		logic [2:0]  f;
		logic        flag;
	} step_s;
	typedef struct {
		logic [4:0]  sel;
		logic [31:0] data;
	} wr_s;
	logic        ref_clk     = 1'b0;
	logic        nrst        = 1'b0;
	logic        instr_valid = 1'b0;
	logic [31:0] instr       = 32'h00000000;
	logic [31:0] ra          = 32'h00000000;
	logic [31:0] rb          = 32'h00000000;
	logic        break_clear = 1'b0;
	logic        took        = 1'b0;
	logic        instr_ready;
	logic [4:0]  first_source_sel;
	logic [4:0]  second_source_sel;
	logic [31:0] program_counter;
	logic        dest_we;
	logic [4:0]  dest_sel;
	logic [31:0] dest_data;
	logic        branch_taken;
	logic        delay_slot;
	logic        break_in_progress_flag;
	logic        illegal_op;
	step_s       step_q[$];
	wr_s         wr_q[$];
	logic [31:0] pc_m;
	logic        flag_m;
	integer      seed        = 32'h1de4dc46;
	int          errors      = 0;
	int          compares    = 0;

	branch_and_barrel_shift_exec #(
		.BARREL_EN (1'b1)
	) i_branch_and_barrel_shift_exec (
		.ref_clk                (ref_clk),
		.nrst                   (nrst),
		.instr_valid            (instr_valid),
		.instr                  (instr),
		.instr_ready            (instr_ready),
		.first_source_sel       (first_source_sel),
		.second_source_sel      (second_source_sel),
		.first_source_reg       (ra),
		.second_source_reg      (rb),
		.break_clear            (break_clear),
		.program_counter        (program_counter),
		.dest_we                (dest_we),
		.dest_sel               (dest_sel),
		.dest_data              (dest_data),
		.branch_taken           (branch_taken),
		.delay_slot             (delay_slot),
		.break_in_progress_flag (break_in_progress_flag),
		.illegal_op             (illegal_op)
	);

	always #5 ref_clk = ~ref_clk;

	task automatic conclude;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic cmp(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_step(input step_s n);
		cmp("program_counter", n.pc, program_counter);
		cmp("taken_slot_illegal_flag", 32'({n.f, n.flag}),
			32'({branch_taken, delay_slot, illegal_op,
			break_in_progress_flag}));
	endtask

	task automatic chk_wr(input wr_s n);
		cmp("dest_sel", 32'(n.sel), 32'(dest_sel));
		cmp("dest_data", n.data, dest_data);
	endtask

	task automatic chk_lat(input int e, input int g);
		cmp("ready_wait", 32'(e), 32'(g));
	endtask

	task automatic chk_sel(input logic [4:0] a, input logic [4:0] b);
		cmp("first_source_sel", 32'(a), 32'(first_source_sel));
		cmp("second_source_sel", 32'(b), 32'(second_source_sel));
	endtask

	function automatic logic [5:0] op(input logic [5:0] base, input bit im);
		return im ? (base | branch_exec_pkg::IMM_FORM_MASK) : base;
	endfunction

	// entered at a rising edge with instr_ready high
	task automatic issue(input logic [31:0] ins, input logic [31:0] a,
		input logic [31:0] b, input logic [31:0] npc, input logic [2:0] f,
		input logic we, input logic [4:0] ds, input logic [31:0] dd,
		input int lat);
		int n;
		step_q.push_back('{npc, f, flag_m});
		if (we) wr_q.push_back('{ds, dd});
		instr <= ins;
		ra <= a;
		rb <= b;
		instr_valid <= 1'b1;
		@(posedge ref_clk);
		instr_valid <= 1'b0;
		pc_m = npc;
		n = 0;
		@(negedge ref_clk);
		chk_sel(ins[20:16], ins[15:11]);
		while (instr_ready !== 1'b1 && n < 8) begin
			n++;
			@(negedge ref_clk);
		end
		chk_lat(lat - 1, n);
		if (n >= 8) conclude();
		@(posedge ref_clk);
	endtask

	task automatic go(input logic [31:0] ins, input logic [31:0] a,
		input logic [31:0] b, input logic [31:0] npc, input logic [2:0] f,
		input int lat);
		issue(ins, a, b, npc, f, 1'b0, 5'h00, 32'h0, lat);
	endtask

	task automatic do_shift(input bit im, input logic [4:0] amt,
		input logic [31:0] npc);
		logic [31:0] a, b, res;
		logic [4:0]  rd;
		logic        s, t;
		a = $random(seed);
		b = $random(seed);
		b[4:0] = amt;
		rd = 5'($random(seed));
		{s, t} = 2'($random(seed));
		if (s) res = a << amt;
		else if (t) res = 32'($signed(a) >>> amt);
		else res = a >> amt;
		issue({op(branch_exec_pkg::OP_SHIFT, im), rd, 5'h01,
			im ? 5'h00 : 5'h02, s, t, 4'h0, im ? amt : 5'h00},
			a, b, npc, 3'b000, 1'b1, rd, res, 2);
	endtask

	// results are matched against the oldest note of their kind
	always @(posedge ref_clk) begin
		took <= nrst && instr_valid && instr_ready;
	end
	always @(negedge ref_clk) begin
		if (took === 1'b1) begin
			if (step_q.size() == 0) cmp("step_note", 32'h1, 32'h0);
			else chk_step(step_q.pop_front());
		end
		if (dest_we === 1'b1) begin
			if (wr_q.size() == 0) cmp("dest_note", 32'h1, 32'h0);
			else chk_wr(wr_q.pop_front());
		end
	end

	initial begin
		logic [31:0] a, b, v, tgt, ins;
		logic [15:0] lit, hi;
		logic [4:0]  rd;
		logic        im, d, tk, aa, l;
		pc_m = 32'h0;
		flag_m = 1'b0;
		repeat (11) @(posedge ref_clk);
		@(negedge ref_clk);
		// reset values
		chk_step('{32'h0, 3'b000, 1'b0});
		cmp("instr_ready", 32'h1, 32'(instr_ready));
		@(posedge ref_clk);
		nrst <= 1'b1;
		@(posedge ref_clk);
		// not-equal branches, both forms, taken or not, with and without slot
		for (int i = 0; i < 8; i++) begin
			{im, tk, d} = 3'(i);
			lit = 16'($random(seed));
			b = $random(seed);
			a = tk ? (32'h80000000 >> i) : 32'h0;
			v = im ? {{16{lit[15]}}, lit} : b;
			tgt = pc_m + v;
			ins = {op(branch_exec_pkg::OP_BCOND, im), d,
				branch_exec_pkg::COND_NE, 5'h03, im ? lit : 16'h2000};
			if (!tk) go(ins, a, b, pc_m + 32'h4, 3'b000, 1);
			else if (!d) go(ins, a, b, tgt, 3'b100, 3);
			else begin
				go(ins, a, b, pc_m + 32'h4, 3'b110, 2);
				do_shift(1'b0, 5'($random(seed)), tgt);
			end
		end
		// every flag mix of the unconditional and break forms
		for (int i = 0; i < 16; i++) begin
			{im, d, aa, l} = 4'(i);
			lit = 16'($random(seed));
			a = $random(seed);
			b = $random(seed);
			rd = 5'($random(seed));
			v = im ? {{16{lit[15]}}, lit} : b;
			tgt = aa ? v : pc_m + v;
			ins = {op(branch_exec_pkg::OP_BUNC, im), rd, d, aa, l, 2'b00,
				im ? lit : 16'h2000};
			if (l && !d && !aa) go(ins, a, b, pc_m + 32'h4, 3'b001, 1);
			else if (l && !d) begin
				flag_m = 1'b1;
				issue(ins, a, b, v, 3'b100, 1'b1, rd, pc_m, 3);
			end else if (d) begin
				issue(ins, a, b, pc_m + 32'h4, 3'b110, l, rd, pc_m, 2);
				do_shift(1'b1, 5'($random(seed)), tgt);
			end else go(ins, a, b, tgt, 3'b100, 3);
			if (i == 5) begin
				break_clear <= 1'b1;
				@(posedge ref_clk);
				break_clear <= 1'b0;
				flag_m = 1'b0;
			end
		end
		// prefix joins upper half, then is dropped after one instruction
		hi = 16'($random(seed));
		lit = 16'($random(seed));
		ins = {branch_exec_pkg::OP_PREFIX, 10'h000, hi};
		go(ins, 32'h0, 32'h0, pc_m + 32'h4, 3'b000, 1);
		go({op(branch_exec_pkg::OP_BUNC, 1'b1), 5'h00, 3'b010, 2'b00, lit},
			32'h0, 32'h0, {hi, lit}, 3'b100, 3);
		go(ins, 32'h0, 32'h0, pc_m + 32'h4, 3'b000, 1);
		do_shift(1'b1, 5'h03, pc_m + 32'h4);
		go({op(branch_exec_pkg::OP_BUNC, 1'b1), 5'h00, 3'b000, 2'b00, lit},
			32'h0, 32'h0, pc_m + {{16{lit[15]}}, lit}, 3'b100, 3);
		// opcodes and conditions outside the set
		go({6'h00, 26'($random(seed))}, 32'h1, 32'h1, pc_m + 32'h4,
			3'b001, 1);
		go({op(branch_exec_pkg::OP_BCOND, 1'b1), 1'b0, 4'h2, 5'h03, 16'h0010},
			32'h1, 32'h0, pc_m + 32'h4, 3'b001, 1);
		// shift amounts incl. zero and maximum
		for (int i = 0; i < 12; i++) begin
			do_shift(i[0], i < 2 ? 5'h00 : (i < 4 ? 5'h1F : 5'($random(seed))),
				pc_m + 32'h4);
		end
		repeat (3) @(posedge ref_clk);
		cmp("pending_notes", 32'h0, 32'(step_q.size() + wr_q.size()));
		conclude();
	end
endmodule
